// file: inc/dtr_pkg.sv
// Purpose: constants and types for the dram timing and refresh block
// Assumes: one controller clock, registers reached by index over a byte port
// Notes: every timing figure here is in controller clock cycles, except ZQ_REFRESH_COUNT, which counts refresh requests
package dtr_pkg;
	// register indices
	localparam logic [7:0] REG_CAS_LATENCY = 8'hc0;
	localparam logic [7:0] REG_ROW_OPEN_PRECHARGE = 8'hc1;
	localparam logic [7:0] REG_ACTIVE_WINDOW_RECOVERY = 8'hc2;
	localparam logic [7:0] REG_FOUR_ACTIVATE_WINDOW = 8'hc3;
	localparam logic [7:0] REG_EIGHT_BANK_TURNAROUND = 8'hc4;
	localparam logic [7:0] REG_CKE_REFRESH_CYCLE = 8'hc5;
	localparam logic [7:0] REG_LOW_POWER_EXIT = 8'hc6;
	localparam logic [7:0] REG_REFRESH_INTERVAL = 8'hc7;
	localparam logic [7:0] REG_CALIB_PRECHARGE_ALL = 8'hc8;
	// writable bit masks (reserved bits read zero)
	localparam logic [7:0] MASK_C0 = 8'h77;
	localparam logic [7:0] MASK_C1 = 8'h77;
	localparam logic [7:0] MASK_C2 = 8'hf7;
	localparam logic [7:0] MASK_C3 = 8'hf7;
	localparam logic [7:0] MASK_C4 = 8'hb7;
	localparam logic [7:0] MASK_C5 = 8'hff;
	localparam logic [7:0] MASK_C6 = 8'h87;
	localparam logic [7:0] MASK_C7 = 8'hff;
	localparam logic [7:0] MASK_C8 = 8'h83;
	localparam logic [7:0] REG_RESET = 8'h00;
	// memory type codes
	localparam logic [1:0] MEM_TYPE_DDR2 = 2'h1;
	localparam logic [1:0] MEM_TYPE_DDR3 = 2'h2;
	// field decode bases, in cycles
	localparam logic [9:0] BASE_CL_DDR2 = 10'h002;
	localparam logic [9:0] BASE_T2 = 10'h002;
	localparam logic [9:0] BASE_T3 = 10'h003;
	localparam logic [9:0] BASE_T4 = 10'h004;
	localparam logic [9:0] BASE_RAS_DDR2 = 10'h005;
	localparam logic [9:0] BASE_RAS_DDR3 = 10'h00f;
	localparam logic [9:0] BASE_RFC = 10'h00a;
	localparam logic [9:0] BASE_RFC_8B = 10'h01e;
	localparam logic [9:0] BASE_ONE = 10'h001;
	localparam logic [9:0] SR_EXIT_SHORT = 10'h0c8;
	localparam logic [9:0] SR_EXIT_LONG = 10'h200;
	// refresh granularity shifts: x16 and x32
	localparam int REF_SHIFT_DDR2 = 4;
	localparam int REF_SHIFT_DDR3 = 5;
	localparam int ZQ_REFRESH_COUNT = 16 * 1024;
	localparam int TW = 10;
	// command codes from the scheduler
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD = 3'h2,
		CMD_WR = 3'h3,
		CMD_PRE = 3'h4,
		CMD_PREA = 3'h5,
		CMD_REF = 3'h6,
		CMD_ZQCS = 3'h7
	} dtr_cmd_type;
	// register port bundle
	typedef struct packed {
		logic wr;
		logic [7:0] idx;
		logic [7:0] wdata;
	} dtr_reg_req_type;
	// decoded timings handed to the scheduler
	typedef struct packed {
		logic [TW-1:0] cas_rd;
		logic [TW-1:0] cas_wr;
		logic [TW-1:0] rcd;
		logic [TW-1:0] rp;
		logic [TW-1:0] ras;
		logic [TW-1:0] wr_rec;
		logic [TW-1:0] faw;
		logic [TW-1:0] rrd;
		logic [TW-1:0] rtp;
		logic [TW-1:0] wtr;
		logic [TW-1:0] cke_min;
		logic [TW-1:0] rfc;
		logic [TW-1:0] sr_exit;
		logic [TW-1:0] pd_exit;
		logic [TW-1:0] rp_all;
	} dtr_timing_type;
endpackage : dtr_pkg

// file: design/dtr_down_counter.sv
// Purpose: one spacing down-counter that blocks a command until expiry
// Assumes: load value is the least spacing in cycles, at least one
// Notes: done is high once the spacing has elapsed
`timescale 1ns/1ps
module dtr_down_counter
	import dtr_pkg::*;
#(
	parameter int W = TW
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// control
	input wire logic load,
	input wire logic [W-1:0] value,
	// status
	output logic done
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} dtr_dc_state_type;
	dtr_dc_state_type st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (load) begin
			// the issue cycle itself counts as the first cycle
			nxt_st.cnt = (value > W'(1)) ? value - W'(1) : '0;
		end else if (st_ff.cnt != '0) begin
			nxt_st.cnt = st_ff.cnt - W'(1);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign done = (st_ff.cnt == '0);

	// a reload restarts the count, so only undisturbed runs are judged
	property p_count_down;
		@(posedge clock) disable iff (!rst_b)
		(load && value == W'(3)) ##1 !load ##1 !load
		|-> !$past(done) && !done ##1 done;
	endproperty
	a_count_down: assert property (p_count_down)
		else $error("spacing counter did not expire on time");
endmodule : dtr_down_counter

// file: design/dtr_refresh_timer.sv
// Purpose: refresh interval timer and short calibration request counter
// Assumes: count of zero holds the timer idle
// Notes: a new count takes effect at once, against the interval already in progress
`timescale 1ns/1ps
module dtr_refresh_timer
	import dtr_pkg::*;
#(
	parameter int ZQ_COUNT = ZQ_REFRESH_COUNT
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// configuration
	input wire logic [7:0] refresh_count_field,
	input wire logic long_unit,
	input wire logic zq_enable,
	// requests
	output logic refresh_req,
	output logic zq_req
);
	typedef struct packed {
		logic [12:0] tick;
		logic [14:0] zq_cnt;
		logic ref_p;
		logic zq_p;
	} dtr_rt_state_type;
	dtr_rt_state_type st_ff, nxt_st;
	logic [12:0] limit;

	always_comb begin
		limit = long_unit ? {refresh_count_field, 5'h00}
			: {1'b0, refresh_count_field, 4'h0};
		nxt_st = st_ff;
		nxt_st.ref_p = 1'b0;
		nxt_st.zq_p = 1'b0;
		if (refresh_count_field == 8'h00) begin
			nxt_st.tick = '0;
		end else if (st_ff.tick >= limit - 13'h0001) begin
			nxt_st.tick = '0;
			nxt_st.ref_p = 1'b1;
			if (zq_enable) begin
				if (st_ff.zq_cnt == 15'(ZQ_COUNT - 1)) begin
					nxt_st.zq_cnt = '0;
					nxt_st.zq_p = 1'b1;
				end else begin
					nxt_st.zq_cnt = st_ff.zq_cnt + 15'h0001;
				end
			end
		end else begin
			nxt_st.tick = st_ff.tick + 13'h0001;
		end
		if (!zq_enable) begin
			nxt_st.zq_cnt = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign refresh_req = st_ff.ref_p;
	assign zq_req = st_ff.zq_p;

	property p_ref_off;
		@(posedge clock) disable iff (!rst_b)
		(refresh_count_field == 8'h00) ##1 (refresh_count_field == 8'h00)
		|-> !refresh_req;
	endproperty
	a_ref_off: assert property (p_ref_off)
		else $error("refresh request while refresh disabled");

	property p_zq_with_ref;
		@(posedge clock) disable iff (!rst_b)
		zq_req |-> refresh_req;
	endproperty
	a_zq_with_ref: assert property (p_zq_with_ref)
		else $error("calibration request without refresh request");
endmodule : dtr_refresh_timer

// file: design/dtr_timing_control.sv
// Purpose: dram timing registers, spacing guards and refresh scheduling
// Assumes: scheduler asks before issuing and reports each issued command
// Notes: one guard set per block; ranks share the guards
// How it works
// - timing fields decode by memory type: 01b ddr2, 10b ddr3
// - ddr2 cas latency 3 to 9 for reads and writes, code 0 invalid
// - ddr3 read cas latency is code plus 4
// - read or write waits activate-to-access delay, 2-9 ddr2, 4-11 ddr3
// - activate waits precharge period after precharge
// - precharge waits row-open time after activate, 5-20 or 15-30
// - write recovery 2 plus code ddr2, 4 plus code ddr3
// - fifth activate waits four rrd plus extra code when enabled
// - activates spaced by rrd, code plus 2
// - one bit enables eight-bank window, refresh and precharge-all terms
// - read-to-precharge 2-5 ddr2, 3-6 ddr3, plus one if extended
// - write-to-read turnaround code plus 2; software avoids 0 on ddr3
// - clock enable stays asserted at least the programmed pulse width
// - after refresh, no activate or refresh for refresh cycle time
// - self-refresh drops clock enable, exit raises it
// - after self-refresh exit wait 200 or 512 cycles
// - power-down drops clock enable; exit waits code plus 1
// - refresh timer requests every count times 16 or 32 cycles
// - short calibration every 16384 refresh requests when enabled
// - precharge-all adds 0-3 cycles with eight-bank constraint
// - ddr3 write cas latency is its own field plus 4
`timescale 1ns/1ps
module dtr_timing_control
	import dtr_pkg::*;
#(
	parameter int RANKS = 4,
	parameter int ZQ_COUNT = ZQ_REFRESH_COUNT
) (
	// clock and reset
	input wire logic controller_clock,
	input wire logic rst_b,
	// register port
	input wire dtr_reg_req_type reg_req,
	output logic [7:0] reg_rdata,
	// configuration from other registers
	input wire logic [1:0] memory_type_select,
	input wire logic read_precharge_extend_bit,
	// scheduler side
	input wire dtr_cmd_type cmd_query,
	input wire dtr_cmd_type cmd_issued,
	output logic cmd_allowed,
	output dtr_timing_type timing,
	output logic refresh_req,
	output logic zq_req,
	// low power control
	input wire logic self_refresh_req,
	input wire logic power_down_req,
	output logic [RANKS-1:0] mem_clock_enable_out
);
	localparam int NG = 8;
	localparam int G_RCD = 0;
	localparam int G_RP = 1;
	localparam int G_RAS = 2;
	localparam int G_RRD = 3;
	localparam int G_RTP = 4;
	localparam int G_WTR = 5;
	localparam int G_RFC = 6;
	localparam int G_EXIT = 7;

	typedef enum logic [1:0] {
		LP_ACTIVE = 2'h0,
		LP_SELF = 2'h1,
		LP_POWER = 2'h2
	} dtr_lp_type;

	typedef struct packed {
		logic [7:0] c0;
		logic [7:0] c1;
		logic [7:0] c2;
		logic [7:0] c3;
		logic [7:0] c4;
		logic [7:0] c5;
		logic [7:0] c6;
		logic [7:0] c7;
		logic [7:0] c8;
		dtr_lp_type lp;
		logic [TW-1:0] cke_cnt;
		logic [TW-1:0] faw_cnt;
		logic [2:0] act_seen;
		logic [7:0] rdata;
		dtr_timing_type timing;
	} dtr_tc_state_type;
	dtr_tc_state_type st_ff, nxt_st;

	logic is_ddr3;
	logic eight_bank_constraint_enable;
	logic [NG-1:0] g_load;
	logic [NG-1:0] g_done;
	logic [TW-1:0] g_val [NG];
	logic wr_issue;
	logic cke_low;
	logic exit_evt;

	function automatic logic [TW-1:0] fld(input logic [3:0] code,
		input logic [TW-1:0] base);
		fld = base + TW'(code);
	endfunction : fld

	function automatic logic [7:0] reg_read(input dtr_tc_state_type s,
		input logic [7:0] idx);
		if (idx == REG_CAS_LATENCY) begin
			reg_read = s.c0;
		end else if (idx == REG_ROW_OPEN_PRECHARGE) begin
			reg_read = s.c1;
		end else if (idx == REG_ACTIVE_WINDOW_RECOVERY) begin
			reg_read = s.c2;
		end else if (idx == REG_FOUR_ACTIVATE_WINDOW) begin
			reg_read = s.c3;
		end else if (idx == REG_EIGHT_BANK_TURNAROUND) begin
			reg_read = s.c4;
		end else if (idx == REG_CKE_REFRESH_CYCLE) begin
			reg_read = s.c5;
		end else if (idx == REG_LOW_POWER_EXIT) begin
			reg_read = s.c6;
		end else if (idx == REG_REFRESH_INTERVAL) begin
			reg_read = s.c7;
		end else if (idx == REG_CALIB_PRECHARGE_ALL) begin
			reg_read = s.c8;
		end else begin
			reg_read = 8'h00;
		end
	endfunction : reg_read

	assign is_ddr3 = (memory_type_select == MEM_TYPE_DDR3);
	assign eight_bank_constraint_enable = st_ff.c4[7];

	// decoded timing, recomputed every cycle
	dtr_timing_type t;
	always_comb begin
		t.cas_rd = is_ddr3 ? fld({1'b0, st_ff.c0[2:0]}, BASE_T4)
			: fld({1'b0, st_ff.c0[2:0]}, BASE_CL_DDR2);
		// ddr3 uses its own write latency field, ddr2 shares the read one
		t.cas_wr = is_ddr3 ? fld({1'b0, st_ff.c0[6:4]}, BASE_T4)
			: t.cas_rd;
		t.rcd = fld({1'b0, st_ff.c1[6:4]}, is_ddr3 ? BASE_T4 : BASE_T2);
		t.rp = fld({1'b0, st_ff.c1[2:0]}, is_ddr3 ? BASE_T4 : BASE_T2);
		t.ras = fld(st_ff.c2[7:4],
			is_ddr3 ? BASE_RAS_DDR3 : BASE_RAS_DDR2);
		t.wr_rec = fld({1'b0, st_ff.c2[2:0]},
			is_ddr3 ? BASE_T4 : BASE_T2);
		t.rrd = fld({1'b0, st_ff.c3[2:0]}, BASE_T2);
		t.faw = {t.rrd[TW-3:0], 2'b00} + TW'(st_ff.c3[7:4]);
		t.rtp = fld({2'b00, st_ff.c4[5:4]}, is_ddr3 ? BASE_T3 : BASE_T2)
			+ TW'(read_precharge_extend_bit);
		t.wtr = fld({1'b0, st_ff.c4[2:0]}, BASE_T2);
		t.cke_min = fld({2'b00, st_ff.c5[7:6]}, BASE_ONE);
		t.rfc = eight_bank_constraint_enable
			? BASE_RFC_8B + {3'b000, st_ff.c5[5:0], 1'b0}
			: BASE_RFC + {4'b0000, st_ff.c5[5:0]};
		t.sr_exit = st_ff.c6[7] ? SR_EXIT_LONG : SR_EXIT_SHORT;
		t.pd_exit = fld({1'b0, st_ff.c6[2:0]}, BASE_ONE);
		t.rp_all = eight_bank_constraint_enable
			? t.rp + TW'(st_ff.c8[1:0]) : t.rp;
	end

	// spacing guards
	assign wr_issue = (cmd_issued == CMD_WR);
	assign exit_evt = (st_ff.lp != LP_ACTIVE) && !self_refresh_req
		&& !power_down_req;
	always_comb begin
		g_load = '0;
		g_val[G_RCD] = t.rcd;
		g_val[G_RP] = (cmd_issued == CMD_PREA) ? t.rp_all : t.rp;
		// write recovery also holds off the next precharge
		g_val[G_RAS] = wr_issue ? t.cas_wr + t.wr_rec : t.ras;
		g_val[G_RRD] = t.rrd;
		g_val[G_RTP] = t.rtp;
		g_val[G_WTR] = t.cas_wr + t.wtr;
		g_val[G_RFC] = t.rfc;
		g_val[G_EXIT] = ((st_ff.lp == LP_SELF) ? t.sr_exit : t.pd_exit) + TW'(1);
		case (cmd_issued)
			CMD_ACT: begin
				g_load[G_RCD] = 1'b1;
				g_load[G_RAS] = 1'b1;
				g_load[G_RRD] = 1'b1;
			end
			CMD_PRE, CMD_PREA: g_load[G_RP] = 1'b1;
			CMD_RD: g_load[G_RTP] = 1'b1;
			CMD_WR: begin
				g_load[G_WTR] = 1'b1;
				g_load[G_RAS] = 1'b1;
			end
			CMD_REF: g_load[G_RFC] = 1'b1;
			default: g_load = '0;
		endcase
		g_load[G_EXIT] = exit_evt;
	end

	generate
		for (genvar g = 0; g < NG; g++) begin : gen_guard
			dtr_down_counter #(.W(TW)) u_guard (
				.clock(controller_clock),
				.rst_b(rst_b),
				.load(g_load[g]),
				.value(g_val[g]),
				.done(g_done[g])
			);
		end
	endgenerate

	// issue check
	always_comb begin
		cmd_allowed = g_done[G_EXIT] && (st_ff.lp == LP_ACTIVE);
		case (cmd_query)
			CMD_ACT: cmd_allowed = cmd_allowed && g_done[G_RP]
				&& g_done[G_RRD] && g_done[G_RFC]
				&& (!eight_bank_constraint_enable || st_ff.act_seen < 3'h4
				|| st_ff.faw_cnt == '0);
			CMD_RD: cmd_allowed = cmd_allowed && g_done[G_RCD]
				&& g_done[G_WTR];
			CMD_WR: cmd_allowed = cmd_allowed && g_done[G_RCD];
			CMD_PRE, CMD_PREA: cmd_allowed = cmd_allowed && g_done[G_RAS]
				&& g_done[G_RTP];
			CMD_REF: cmd_allowed = cmd_allowed && g_done[G_RFC];
			CMD_ZQCS: cmd_allowed = cmd_allowed && g_done[G_RFC];
			default: cmd_allowed = 1'b1;
		endcase
	end

	// registers, four-activate window and clock enable state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.timing = t;
		nxt_st.rdata = reg_read(st_ff, reg_req.idx);
		if (reg_req.wr) begin
			if (reg_req.idx == REG_CAS_LATENCY) begin
				nxt_st.c0 = reg_req.wdata & MASK_C0;
			end else if (reg_req.idx == REG_ROW_OPEN_PRECHARGE) begin
				nxt_st.c1 = reg_req.wdata & MASK_C1;
			end else if (reg_req.idx == REG_ACTIVE_WINDOW_RECOVERY) begin
				nxt_st.c2 = reg_req.wdata & MASK_C2;
			end else if (reg_req.idx == REG_FOUR_ACTIVATE_WINDOW) begin
				nxt_st.c3 = reg_req.wdata & MASK_C3;
			end else if (reg_req.idx == REG_EIGHT_BANK_TURNAROUND) begin
				nxt_st.c4 = reg_req.wdata & MASK_C4;
			end else if (reg_req.idx == REG_CKE_REFRESH_CYCLE) begin
				nxt_st.c5 = reg_req.wdata & MASK_C5;
			end else if (reg_req.idx == REG_LOW_POWER_EXIT) begin
				nxt_st.c6 = reg_req.wdata & MASK_C6;
			end else if (reg_req.idx == REG_REFRESH_INTERVAL) begin
				nxt_st.c7 = reg_req.wdata & MASK_C7;
			end else if (reg_req.idx == REG_CALIB_PRECHARGE_ALL) begin
				nxt_st.c8 = reg_req.wdata & MASK_C8;
			end
		end
		// window opens at the first of four activates, approximated
		// as a fixed start: a simpler guard that can under-wait
		if (st_ff.faw_cnt != '0) begin
			nxt_st.faw_cnt = st_ff.faw_cnt - TW'(1);
		end else begin
			nxt_st.act_seen = 3'h0;
		end
		if (cmd_issued == CMD_ACT) begin
			if (st_ff.faw_cnt == '0) begin
				nxt_st.faw_cnt = t.faw - TW'(1);
				nxt_st.act_seen = 3'h1;
			end else if (st_ff.act_seen < 3'h4) begin
				nxt_st.act_seen = st_ff.act_seen + 3'h1;
			end
		end
		if (st_ff.cke_cnt != '0) begin
			nxt_st.cke_cnt = st_ff.cke_cnt - TW'(1);
		end
		case (st_ff.lp)
			LP_ACTIVE: begin
				// hold clock enable high for the least pulse width
				if (st_ff.cke_cnt == '0) begin
					if (self_refresh_req) begin
						nxt_st.lp = LP_SELF;
					end else if (power_down_req) begin
						nxt_st.lp = LP_POWER;
					end
				end
			end
			LP_SELF, LP_POWER: begin
				if (exit_evt) begin
					nxt_st.lp = LP_ACTIVE;
					nxt_st.cke_cnt = t.cke_min - TW'(1);
				end
			end
			default: nxt_st.lp = LP_ACTIVE;
		endcase
	end

	always_ff @(posedge controller_clock) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cke_low = (st_ff.lp != LP_ACTIVE);
	assign mem_clock_enable_out = {RANKS{!cke_low}};
	assign reg_rdata = st_ff.rdata;
	assign timing = st_ff.timing;

	dtr_refresh_timer #(.ZQ_COUNT(ZQ_COUNT)) u_refresh (
		.clock(controller_clock),
		.rst_b(rst_b),
		.refresh_count_field(st_ff.c7),
		.long_unit(is_ddr3),
		.zq_enable(st_ff.c8[7]),
		.refresh_req(refresh_req),
		.zq_req(zq_req)
	);

	property p_sr_exit_wait;
		@(posedge controller_clock) disable iff (!rst_b)
		(st_ff.lp == LP_SELF && exit_evt && !st_ff.c6[7])
		|=> !cmd_allowed [*8];
	endproperty
	a_sr_exit_wait: assert property (p_sr_exit_wait)
		else $error("command allowed too soon after self-refresh exit");

	property p_cke_low;
		@(posedge controller_clock) disable iff (!rst_b)
		(st_ff.lp == LP_SELF) |-> mem_clock_enable_out == '0;
	endproperty
	a_cke_low: assert property (p_cke_low)
		else $error("clock enable high in self-refresh");

	property p_rrd;
		@(posedge controller_clock) disable iff (!rst_b)
		(cmd_issued == CMD_ACT && st_ff.c3[2:0] == 3'h0)
		|=> !(cmd_query == CMD_ACT && cmd_allowed);
	endproperty
	a_rrd: assert property (p_rrd)
		else $error("activate spacing not enforced");

	property p_rfc;
		@(posedge controller_clock) disable iff (!rst_b)
		(cmd_issued == CMD_REF)
		|=> !(cmd_query == CMD_REF && cmd_allowed) [*8];
	endproperty
	a_rfc: assert property (p_rfc)
		else $error("refresh cycle time not enforced");

	property p_rcd;
		@(posedge controller_clock) disable iff (!rst_b)
		(cmd_issued == CMD_ACT)
		|=> !(cmd_query == CMD_RD && cmd_allowed);
	endproperty
	a_rcd: assert property (p_rcd)
		else $error("read allowed right after activate");

	property p_cas_ddr3;
		@(posedge controller_clock) disable iff (!rst_b)
		is_ddr3 |=> timing.cas_rd == TW'($past(st_ff.c0[2:0])) + TW'(4);
	endproperty
	a_cas_ddr3: assert property (p_cas_ddr3)
		else $error("ddr3 read latency decode wrong");

	property p_rp_all;
		@(posedge controller_clock) disable iff (!rst_b)
		!eight_bank_constraint_enable |=> timing.rp_all == timing.rp;
	endproperty
	a_rp_all: assert property (p_rp_all)
		else $error("precharge-all extension applied while disabled");

	property p_ras;
		@(posedge controller_clock) disable iff (!rst_b)
		(cmd_issued == CMD_ACT)
		|=> !(cmd_query == CMD_PRE && cmd_allowed) [*4];
	endproperty
	a_ras: assert property (p_ras)
		else $error("row closed before row-open time");
endmodule : dtr_timing_control

// file: tb/dtr_dram_model.sv
// Purpose: far-side memory model that watches the issued command stream
// Assumes: one command a cycle, NOP when idle
// Notes: a rank with clock enable low ignores the bus, so a command then
// is lost; such commands are counted for the bench to judge
`timescale 1ns/1ps
module dtr_dram_model
	import dtr_pkg::*;
#(
	parameter int RANKS = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// memory bus
	input wire dtr_cmd_type cmd,
	input wire logic [RANKS-1:0] cke,
	// status
	output logic [7:0] bad_ff
);
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			bad_ff <= 8'h00;
		end else if (cmd != CMD_NOP && cke != {RANKS{1'b1}}) begin
			bad_ff <= bad_ff + 8'h01;
		end
	end
endmodule : dtr_dram_model

// file: tb/test_dram_timing_refresh_control.sv
// Purpose: self-checking bench for the timing and refresh block
// Assumes: expected spacings worked out from the field codes
// Notes: each measurement starts from idle so no earlier guard is still running
`timescale 1ns/1ps
module test_dram_timing_refresh_control
	import dtr_pkg::*;
;
	logic clock, rst_b, ext, allowed, rreq, zreq, sr, pd, res_v;
	dtr_reg_req_type req;
	logic [7:0] rdata, bad, v;
	logic [1:0] mtype;
	dtr_cmd_type q, iss;
	dtr_timing_type timing;
	logic [3:0] cke;
	logic [15:0] res;
	logic [15:0] expq[$];
	logic [31:0] r, s;
	int n_errors, n_checks, seed, cl, cw, b, casw, rfc, rc;
	localparam logic [7:0] MK [10] = '{MASK_C0, MASK_C1, MASK_C2, MASK_C3,
		MASK_C4, MASK_C5, MASK_C6, MASK_C7, MASK_C8, 8'h00};

	dtr_timing_control #(.RANKS(4), .ZQ_COUNT(4)) dut (
		.controller_clock(clock), .rst_b(rst_b), .reg_req(req),
		.reg_rdata(rdata), .memory_type_select(mtype),
		.read_precharge_extend_bit(ext), .cmd_query(q), .cmd_issued(iss),
		.cmd_allowed(allowed), .timing(timing), .refresh_req(rreq),
		.zq_req(zreq), .self_refresh_req(sr), .power_down_req(pd),
		.mem_clock_enable_out(cke));
	dtr_dram_model #(.RANKS(4)) mdl (.clock(clock), .rst_b(rst_b),
		.cmd(iss), .cke(cke), .bad_ff(bad));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	always @(posedge clock) begin
		if (res_v) begin
			n_checks++;
			if (expq.size() == 0 || res !== expq[0]) begin
				n_errors++;
				$display("FAIL %0t got %h exp %h", $time, res, expq[0]);
			end
			if (expq.size() != 0) void'(expq.pop_front());
		end
	end

	task automatic end_sim;
		n_checks++;
		if (bad !== 8'h00) n_errors++;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic step(inout int k);
		@(posedge clock);
		k++;
		#1;
		if (k > 1000) begin
			n_errors++;
			end_sim;
		end
	endtask : step

	task automatic chk(input logic [15:0] got, input int e);
		expq.push_back(16'(e));
		@(posedge clock);
		res <= got;
		res_v <= 1'b1;
		@(posedge clock);
		res_v <= 1'b0;
	endtask : chk

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(posedge clock);
		req <= '{wr: 1'b1, idx: i, wdata: d};
		@(posedge clock);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		@(posedge clock);
		req.idx <= i;
		@(posedge clock);
		#1;
		chk({8'h00, rdata}, e);
	endtask : rd

	// first command issued, then cycles counted until the second may go
	task automatic sp(input dtr_cmd_type a, input dtr_cmd_type c, input int e);
		int k;
		repeat (170) @(posedge clock);
		q <= c;
		iss <= a;
		@(posedge clock);
		iss <= CMD_NOP;
		k = 1;
		#1;
		while (allowed !== 1'b1) step(k);
		chk(16'(k), e);
	endtask : sp

	// four activates at the least spacing, then the wait for a fifth
	task automatic fw(input int rrd, input int e);
		int k;
		repeat (170) @(posedge clock);
		q <= CMD_ACT;
		repeat (4) begin
			iss <= CMD_ACT;
			@(posedge clock);
			iss <= CMD_NOP;
			repeat (rrd - 1) @(posedge clock);
		end
		k = 4 * rrd;
		#1;
		while (allowed !== 1'b1) step(k);
		chk(16'(k), e);
	endtask : fw

	task automatic lp(input bit self, input int e);
		int k;
		repeat (170) @(posedge clock);
		q <= CMD_ACT;
		sr <= self;
		pd <= !self;
		k = 0;
		do step(k); while (cke !== 4'h0);
		chk({15'h0, allowed}, 0);
		sr <= 1'b0;
		pd <= 1'b0;
		k = 0;
		do step(k); while (cke !== 4'hf);
		k = 0;
		do step(k); while (allowed !== 1'b1);
		chk(16'(k), e);
	endtask : lp

	task automatic gap(input bit z, input int e);
		int k;
		k = 0;
		do step(k); while ((z ? zreq : rreq) !== 1'b1);
		k = 0;
		do step(k); while ((z ? zreq : rreq) !== 1'b1);
		chk(16'(k), e);
	endtask : gap

	initial begin
		seed = 37186;
		req = '0;
		mtype = MEM_TYPE_DDR2;
		{ext, sr, pd, res_v, rst_b} = 5'h0;
		q = CMD_NOP;
		iss = CMD_NOP;
		res = 16'h0000;
		n_errors = 0;
		n_checks = 0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		for (int i = 0; i < 10; i++) rd(8'(8'hc0 + i), 8'h00);
		for (int i = 0; i < 10; i++) begin
			v = 8'($random(seed));
			wr(8'(8'hc0 + i), v);
			rd(8'(8'hc0 + i), v & MK[i]); // reserved bits and unmapped c9
		end
		for (int m = 0; m < 4; m++) begin
			r = $random(seed);
			s = $random(seed);
			mtype <= m[0] ? MEM_TYPE_DDR3 : MEM_TYPE_DDR2;
			ext <= m[1];
			b = m[0] ? 4 : 2;
			cl = 1 + r[2:0] % 7;
			cw = r[5:3];
			casw = m[0] ? cw + 4 : cl + 2;
			rfc = s[5:0];
			rc = 1 + s[7:6];
			wr(8'hc0, {1'b0, r[5:3], 1'b0, 3'(cl)});
			wr(8'hc1, {1'b0, r[8:6], 1'b0, r[11:9]});
			wr(8'hc2, {r[15:12], 1'b0, r[18:16]});
			wr(8'hc3, {s[11:8], 1'b0, r[21:19]});
			wr(8'hc4, {m[1], 1'b0, r[23:22], 1'b0, 3'(1 + r[26:24] % 7)});
			wr(8'hc5, {2'h0, s[5:0]});
			wr(8'hc6, {m[0] | s[12], 4'h0, s[15:13]});
			wr(8'hc8, {m[0], 5'h0, s[17:16]});
			sp(CMD_ACT, CMD_ACT, r[21:19] + 2);
			fw(r[21:19] + 2,
				4 * (r[21:19] + 2) + (m[1] ? s[11:8] : 0));
			chk({6'h0, timing.cas_rd}, m[0] ? cl + 4 : cl + 2);
			chk({6'h0, timing.cas_wr}, casw);
			sp(CMD_ACT, CMD_RD, r[8:6] + b);
			sp(CMD_ACT, CMD_WR, r[8:6] + b);
			sp(CMD_PRE, CMD_ACT, r[11:9] + b);
			sp(CMD_ACT, CMD_PRE, r[15:12] + (m[0] ? 15 : 5));
			sp(CMD_RD, CMD_PRE, r[23:22] + 2 + m[0] + m[1]);
			sp(CMD_WR, CMD_PRE, casw + r[18:16] + b);
			sp(CMD_WR, CMD_RD, casw + 3 + r[26:24] % 7);
			sp(CMD_REF, CMD_ACT, m[1] ? 30 + 2 * rfc : 10 + rfc);
			sp(CMD_REF, CMD_REF, m[1] ? 30 + 2 * rfc : 10 + rfc);
			sp(CMD_PREA, CMD_ACT, r[11:9] + b + (m[1] ? s[17:16] : 0));
			lp(1'b1, (m[0] | s[12]) ? 512 : 200);
			lp(1'b0, s[15:13] + 1);
			wr(8'hc7, 8'(rc));
			gap(1'b0, rc * (m[0] ? 32 : 16));
			if (m[0]) gap(1'b1, 4 * 32 * rc);
			wr(8'hc7, 8'h00);
		end
		end_sim;
	end
endmodule : test_dram_timing_refresh_control
